// >>> rtl/debug_regs_defs.svh
// offsets, field positions and reset values of the debug register pair
`ifndef DEBUG_REGS_DEFS_SVH
`define DEBUG_REGS_DEFS_SVH
`define REG_NUM_IDENT 4'h0
`define REG_NUM_STATUS 4'h1
`define CHAIN_IDENT 5'h00
`define CHAIN_STATUS 5'h01
`define ID_WATCH_LSB 28
`define ID_BREAK_LSB 24
`define ID_CTX_LSB 20
`define ID_VER_LSB 16
`define ID_VAR_LSB 4
`define ID_REV_LSB 0
`define ST_H2C_FULL 30
`define ST_C2H_FULL 29
`define ST_MON_EN 15
`define ST_HALT_SEL 14
`define ST_EXEC_EN 13
`define ST_USER_DIS 12
`define ST_IRQ_DIS 11
`define ST_ACK_FORCE 10
`define ST_PWR_DIS 9
`define ST_IMPRECISE 7
`define ST_PRECISE 6
`define ST_ENTRY_LSB 2
`define ST_RESTARTED 1
`define ST_HALTED 0
`define ENTRY_RST 4'h0
`define RESTARTED_RST 1'b1
`define CORE_WR_MASK 32'h0000_903C
`define EXT_WR_MASK 32'h0000_6E00
`endif

// >>> rtl/debug_regs_pkg.sv
// types shared by the debug register pair
package debug_regs_pkg;
    typedef enum logic [3:0] {
        entry_halt_cmd = 4'h0,
        entry_breakpoint = 4'h1,
        entry_watchpoint = 4'h2,
        entry_bkpt_insn = 4'h3,
        entry_ext_request = 4'h4,
        entry_vector_catch = 4'h5,
        entry_data_abort = 4'h6,
        entry_insn_abort = 4'h7
    } entry_cause_e;
    typedef struct packed {
        logic rd;
        logic wr;
        logic user_mode;
        logic [3:0] reg_num;
        logic [31:0] wdata;
    } core_req_s;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] chain;
        logic [31:0] wdata;
    } ext_req_s;
    typedef enum {st_normal, st_debug, st_exiting} dbg_state_e;
endpackage

// >>> rtl/debug_id_status_control_regs.sv
// debug identification and status/control registers, core and jtag views
// Function
// - id top nibble: watch pairs minus one
// - id break pair field: six pairs, code five
// - id context-capable break pairs: two, code one
// - id version from parameter; variant, revision from main id
// - id readable externally via chain zero anytime
// - host-to-core full: set host write, core read clears
// - core-to-host full: set core write, host read clears
// - monitor enable core-written; exception needs enable, not halt
// - mode select written only by external debugger
// - execute enable accepts forced instructions in debug state
// - user disable traps unprivileged register access
// - interrupt disable inhibits irq and fiq
// - acknowledge force drives debug acknowledge high
// - powerdown disable output follows its bit
// - sticky imprecise abort cleared by external status read
// - sticky precise abort captures port-issued aborts
// - entry cause field holds the entry reason code written by the core; codes 8 to 15 leave it unchanged
// - restarted bit resets one, low while exiting
// - halted bit high in debug state, resets zero
// - registers reachable by coprocessor and scan chains
`timescale 1ns/1ps
`include "debug_regs_defs.svh"
module debug_id_status_control_regs
    import debug_regs_pkg::*;
#(
    parameter logic [3:0] WATCH_PAIRS = 4'h2,
    parameter logic [3:0] BREAK_PAIRS = 4'h6,
    parameter logic [3:0] CTX_PAIRS = 4'h2,
    parameter logic [3:0] DEBUG_VERSION = 4'h1 // arbitrary value
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [31:0] main_id,
    input wire core_req_s core_req,
    output logic [31:0] core_rdata,
    output logic core_undef,
    input wire ext_req_s ext_req,
    output logic [31:0] ext_rdata,
    input wire logic h2c_data_wr,
    input wire logic h2c_data_rd,
    input wire logic c2h_data_wr,
    input wire logic c2h_data_rd,
    input wire logic imprecise_abort,
    input wire logic precise_abort,
    input wire logic debug_event,
    input wire logic enter_debug,
    input wire logic exit_start,
    input wire logic exit_done,
    input wire logic irq_in,
    input wire logic fiq_in,
    input wire logic core_debug_ack,
    output logic irq_out,
    output logic fiq_out,
    output logic debug_acknowledge_out,
    output logic powerdown_disable_out,
    output logic debug_exception,
    output logic halt_request,
    output logic forced_exec_ok,
    output logic host_to_core_full,
    output logic core_to_host_full
);
    logic [31:0] ctrl_ff, nxt_ctrl;
    logic h2c_ff, nxt_h2c, c2h_ff, nxt_c2h;
    logic imp_ff, nxt_imp, pre_ff, nxt_pre;
    dbg_state_e state_ff, nxt_state;
    logic [31:0] ident, status, nxt_core_rdata, nxt_ext_rdata;
    logic core_id_hit, core_st_hit, core_ok, ext_st_rd;
    logic nxt_undef;

    // identification word built from configuration and main id
    assign ident = {WATCH_PAIRS - 4'h1,
                    BREAK_PAIRS - 4'h1,
                    CTX_PAIRS - 4'h1,
                    DEBUG_VERSION, 8'h00,
                    main_id[23:20], main_id[3:0]};

    // status word; reserved bits are zero
    always_comb begin
        status = 32'h0000_0000;
        status[15:2] = ctrl_ff[15:2];
        status[`ST_H2C_FULL] = h2c_ff;
        status[`ST_C2H_FULL] = c2h_ff;
        status[`ST_IMPRECISE] = imp_ff;
        status[`ST_PRECISE] = pre_ff;
        status[`ST_RESTARTED] = (state_ff != st_exiting);
        status[`ST_HALTED] = (state_ff == st_debug);
    end

    // core access decode, user trap
    assign core_id_hit = core_req.reg_num == `REG_NUM_IDENT;
    assign core_st_hit = core_req.reg_num == `REG_NUM_STATUS;
    assign core_ok = !(core_req.user_mode && ctrl_ff[`ST_USER_DIS]);
    assign ext_st_rd = ext_req.rd && ext_req.chain == `CHAIN_STATUS;

    // control bits, each side writes only its own bits
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_undef = 1'b0;
        if ((core_req.rd || core_req.wr) && !core_ok) begin
            nxt_undef = 1'b1;
        end else if (core_req.wr && core_st_hit) begin
            nxt_ctrl = (ctrl_ff & ~`CORE_WR_MASK) |
                (core_req.wdata & `CORE_WR_MASK);
            if (core_req.wdata[5]) begin
                nxt_ctrl[5:2] = ctrl_ff[5:2]; // reserved codes
            end
        end
        if (ext_req.wr && ext_req.chain == `CHAIN_STATUS) begin
            nxt_ctrl = (nxt_ctrl & ~`EXT_WR_MASK) |
                (ext_req.wdata & `EXT_WR_MASK);
        end
    end

    // channel full flags and sticky aborts; set wins over clear
    always_comb begin
        nxt_h2c = h2c_ff;
        nxt_c2h = c2h_ff;
        nxt_imp = imp_ff;
        nxt_pre = pre_ff;
        if (h2c_data_rd) nxt_h2c = 1'b0;
        if (h2c_data_wr) nxt_h2c = 1'b1;
        if (c2h_data_rd) nxt_c2h = 1'b0;
        if (c2h_data_wr) nxt_c2h = 1'b1;
        if (ext_st_rd) begin
            nxt_imp = 1'b0;
            nxt_pre = 1'b0;
        end
        if (imprecise_abort) nxt_imp = 1'b1;
        if (precise_abort && ctrl_ff[`ST_EXEC_EN]) nxt_pre = 1'b1;
    end

    // debug state tracking
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            st_normal: if (enter_debug) nxt_state = st_debug;
            st_debug: if (exit_start) nxt_state = st_exiting;
            st_exiting: if (exit_done) nxt_state = st_normal;
        endcase
    end

    // read data for both sides
    always_comb begin
        nxt_core_rdata = 32'h0000_0000;
        nxt_ext_rdata = 32'h0000_0000;
        if (core_req.rd && core_ok && core_id_hit) nxt_core_rdata = ident;
        if (core_req.rd && core_ok && core_st_hit) nxt_core_rdata = status;
        if (ext_req.rd && ext_req.chain == `CHAIN_IDENT) begin
            nxt_ext_rdata = ident;
        end
        if (ext_st_rd) nxt_ext_rdata = status;
    end

    // register all state
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff <= 32'h0000_0000;
            h2c_ff <= 1'b0;
            c2h_ff <= 1'b0;
            imp_ff <= 1'b0;
            pre_ff <= 1'b0;
            state_ff <= st_normal;
            core_rdata <= 32'h0000_0000;
            ext_rdata <= 32'h0000_0000;
            core_undef <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            h2c_ff <= nxt_h2c;
            c2h_ff <= nxt_c2h;
            imp_ff <= nxt_imp;
            pre_ff <= nxt_pre;
            state_ff <= nxt_state;
            core_rdata <= nxt_core_rdata;
            ext_rdata <= nxt_ext_rdata;
            core_undef <= nxt_undef;
        end
    end

    // control outputs
    assign irq_out = irq_in && !ctrl_ff[`ST_IRQ_DIS];
    assign fiq_out = fiq_in && !ctrl_ff[`ST_IRQ_DIS];
    assign debug_acknowledge_out = core_debug_ack ||
        ctrl_ff[`ST_ACK_FORCE];
    assign powerdown_disable_out = ctrl_ff[`ST_PWR_DIS];
    assign debug_exception = debug_event && ctrl_ff[`ST_MON_EN] &&
        !ctrl_ff[`ST_HALT_SEL];
    assign halt_request = debug_event && ctrl_ff[`ST_HALT_SEL];
    assign forced_exec_ok = ctrl_ff[`ST_EXEC_EN] &&
        (state_ff == st_debug);
    assign host_to_core_full = h2c_ff;
    assign core_to_host_full = c2h_ff;

    // checks on register contents and control outputs
    AST_ID_CONST: assert property (@(posedge core_clk) disable iff (!rst_b)
        ext_req.rd && ext_req.chain == `CHAIN_IDENT |=> ext_rdata[31:20] ==
        {WATCH_PAIRS - 4'h1, BREAK_PAIRS - 4'h1, CTX_PAIRS - 4'h1})
        else $error("ident fields wrong");

    AST_BREAK_FIELD: assert property (@(posedge core_clk) disable iff (!rst_b)
        ext_req.rd && ext_req.chain == `CHAIN_IDENT
        |=> ext_rdata[27:24] == BREAK_PAIRS - 4'h1 && ext_rdata[27:24] != 4'h0)
        else $error("break pair field wrong");

    AST_CTX_FIELD: assert property (@(posedge core_clk) disable iff (!rst_b)
        core_req.rd && core_ok && core_id_hit
        |=> core_rdata[23:20] == CTX_PAIRS - 4'h1)
        else $error("context pair field wrong");

    AST_ID_MAIN: assert property (@(posedge core_clk) disable iff (!rst_b)
        core_req.rd && core_ok && core_id_hit
        |=> core_rdata[7:0] == {$past(main_id[23:20]), $past(main_id[3:0])})
        else $error("variant or revision wrong");

    AST_EXT_ID_ANY: assert property (@(posedge core_clk) disable iff (!rst_b)
        ext_req.rd && ext_req.chain == `CHAIN_IDENT
        |=> ext_rdata[19:16] == DEBUG_VERSION)
        else $error("external ident read wrong");

    AST_H2C_SET: assert property (@(posedge core_clk) disable iff (!rst_b)
        h2c_data_wr |=> host_to_core_full)
        else $error("h2c full not set");

    AST_H2C_CLR: assert property (@(posedge core_clk) disable iff (!rst_b)
        h2c_data_rd && !h2c_data_wr
        |=> !host_to_core_full)
        else $error("h2c full not cleared");

    AST_C2H_SET: assert property (@(posedge core_clk) disable iff (!rst_b)
        c2h_data_wr
        |=> core_to_host_full)
        else $error("c2h full not set");

    AST_C2H_CLR: assert property (@(posedge core_clk) disable iff (!rst_b)
        c2h_data_rd && !c2h_data_wr |=> !core_to_host_full)
        else $error("c2h full not cleared");

    AST_MON_EXC: assert property (@(posedge core_clk) disable iff (!rst_b)
        debug_exception |-> status[15:14] == 2'b10)
        else $error("exception outside monitor mode");

    AST_HALT_REQ: assert property (@(posedge core_clk) disable iff (!rst_b)
        debug_event && status[`ST_HALT_SEL]
        |-> halt_request && !debug_exception)
        else $error("halt mode event misrouted");

    AST_EXEC_OK: assert property (@(posedge core_clk) disable iff (!rst_b)
        forced_exec_ok
        |-> status[`ST_EXEC_EN] && status[`ST_HALTED])
        else $error("forced execution outside debug state");

    AST_USER_TRAP: assert property (@(posedge core_clk) disable iff (!rst_b)
        core_req.rd && core_req.user_mode && status[`ST_USER_DIS]
        |=> core_undef && core_rdata == 32'h0000_0000)
        else $error("user access not trapped");

    AST_IRQ_MASK: assert property (@(posedge core_clk) disable iff (!rst_b)
        status[`ST_IRQ_DIS] |-> !irq_out && !fiq_out)
        else $error("interrupt not inhibited");

    AST_ACK_FORCE: assert property (@(posedge core_clk) disable iff (!rst_b)
        status[`ST_ACK_FORCE]
        |-> debug_acknowledge_out)
        else $error("acknowledge not forced");

    AST_PWR_PIN: assert property (@(posedge core_clk) disable iff (!rst_b)
        powerdown_disable_out
        == status[`ST_PWR_DIS])
        else $error("powerdown pin mismatch");

    AST_ABORT_CLR: assert property (@(posedge core_clk) disable iff (!rst_b)
        ext_st_rd && !imprecise_abort |=> !status[`ST_IMPRECISE])
        else $error("sticky abort not cleared");

    AST_PRECISE_SET: assert property (@(posedge core_clk) disable iff (!rst_b)
        precise_abort && status[`ST_EXEC_EN]
        |=> status[`ST_PRECISE])
        else $error("precise abort not captured");

    AST_ENTRY_RSV: assert property (@(posedge core_clk) disable iff (!rst_b)
        core_req.wr && core_ok && core_st_hit && core_req.wdata[5]
        |=> status[5:2] == $past(status[5:2]))
        else $error("reserved entry code accepted");

    AST_RESTART: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_ff == st_debug && exit_start |=> !status[`ST_RESTARTED]
        && !status[`ST_HALTED])
        else $error("restart bit wrong on exit");

    AST_HALTED: assert property (@(posedge core_clk) disable iff (!rst_b)
        enter_debug && state_ff == st_normal
        |=> status[`ST_HALTED])
        else $error("halted bit not set");

    AST_ST_READ: assert property (@(posedge core_clk) disable iff (!rst_b)
        core_req.rd && core_ok && core_st_hit
        |=> core_rdata == $past(status))
        else $error("status read wrong");

    AST_RSVD_ZERO: assert property (@(posedge core_clk) disable iff (!rst_b)
        !status[31] && status[28:16] == 13'h0000
        && !status[8])
        else $error("reserved bit set");

    AST_CORE_RO: assert property (@(posedge core_clk) disable iff (!rst_b)
        core_req.wr && !(ext_req.wr && ext_req.chain == `CHAIN_STATUS)
        |=> $stable(status[14:9]) || $past(core_req.wdata[12]) !=
        $past(status[12]))
        else $error("core changed external bit");
endmodule

// >>> tb/ext_debugger_model.sv
// jtag-side debugger model: scan chain reads and writes
`timescale 1ns/1ps
module ext_debugger_model
    import debug_regs_pkg::*;
(
    input wire logic core_clk,
    input wire logic [31:0] ext_rdata,
    output ext_req_s ext_req
);
    logic halted_seen = 1'b0;
    initial ext_req = '0;
    // one transfer: request held over one edge, answer read a cycle on
    task automatic xfer(logic wr, logic [4:0] ch, logic [31:0] d,
                        output logic [31:0] q);
        @(negedge core_clk);
        ext_req = '{rd: ~wr, wr: wr, chain: ch, wdata: d};
        @(negedge core_clk);
        ext_req = '0;
        q = ext_rdata;
        if (!wr && ch == 5'h01) halted_seen = ext_rdata[0];
    endtask
    task automatic xrd(logic [4:0] ch, output logic [31:0] q);
        xfer(1'b0, ch, '0, q);
    endtask
    // execute enable set only once the core is seen halted
    task automatic xwr(logic [4:0] ch, logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, ch, d & ~{18'h0, ~halted_seen, 13'h0}, q);
    endtask
endmodule

// >>> tb/tb.sv
// self-checking bench for the debug id and status/control registers
`timescale 1ns/1ps
module tb
    import debug_regs_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic irq_in = 1'b1;
    logic ack_in = 1'b0;
    logic [9:0] ev = 10'h000;
    core_req_s creq = '0;
    ext_req_s xreq;
    logic [31:0] crd, xrd_w;
    logic undef, irq_o, fiq_o, ack_o, pwr_o, dexc, hreq, fex, h2c, c2h;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    always #12.5 core_clk = ~core_clk;
    debug_id_status_control_regs dut (.core_clk(core_clk), .rst_b(rst_b),
        .main_id(32'h00A0_000C), .core_req(creq), .core_rdata(crd),
        .core_undef(undef), .ext_req(xreq), .ext_rdata(xrd_w),
        .h2c_data_wr(ev[0]), .h2c_data_rd(ev[1]), .c2h_data_wr(ev[2]),
        .c2h_data_rd(ev[3]), .imprecise_abort(ev[4]),
        .precise_abort(ev[5]), .debug_event(ev[6]), .enter_debug(ev[7]),
        .exit_start(ev[8]), .exit_done(ev[9]), .irq_in(irq_in),
        .fiq_in(irq_in), .core_debug_ack(ack_in), .irq_out(irq_o),
        .fiq_out(fiq_o), .debug_acknowledge_out(ack_o),
        .powerdown_disable_out(pwr_o), .debug_exception(dexc),
        .halt_request(hreq), .forced_exec_ok(fex),
        .host_to_core_full(h2c), .core_to_host_full(c2h));
    ext_debugger_model host (.core_clk(core_clk), .ext_rdata(xrd_w),
        .ext_req(xreq));
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one core access, data taken the cycle after the request
    task automatic cop(logic wr, logic usr, logic [3:0] n, logic [31:0] d,
                       output logic [31:0] q);
        @(negedge core_clk);
        creq = '{rd: ~wr, wr: wr, user_mode: usr, reg_num: n, wdata: d};
        @(negedge core_clk);
        q = crd;
        creq = '0;
    endtask
    task automatic pulse(int i);
        @(negedge core_clk);
        ev[i] = 1'b1;
        @(negedge core_clk);
        ev[i] = 1'b0;
    endtask
    // debug event, routing seen while it is high
    task automatic evt(logic [1:0] exp);
        @(negedge core_clk);
        ev[6] = 1'b1;
        #1 chk("event routing", {30'h0, exp}, {30'h0, hreq, dexc});
        @(negedge core_clk);
        ev[6] = 1'b0;
    endtask
    task automatic t_ident();
        logic [31:0] q, id;
        id = {4'h1, 4'h5, 4'h1, 4'h1, 8'h00, 4'hA, 4'hC};
        cop(1'b0, 1'b0, 4'h0, '0, q);
        chk("core ident", id, q);
        host.xrd(5'h00, q);
        chk("ext ident", id, q);
        host.xrd(5'h01, q);
        chk("status reset", 32'h0000_0002, q);
    endtask
    task automatic t_ctrl();
        logic [31:0] q;
        host.xwr(5'h01, 32'hFFFF_FFFF);
        host.xrd(5'h01, q);
        chk("ext write", 32'h0000_4E02, q);
        chk("pins", 32'hC,
            {28'h0, pwr_o, ack_o, irq_o, fiq_o});
        cop(1'b1, 1'b0, 4'h1, 32'hFFFF_FFFF, q);
        cop(1'b0, 1'b0, 4'h1, '0, q);
        chk("core write", 32'h0000_DE02, q);
        evt(2'b10);
        host.xwr(5'h01, 32'h0);
        chk("pins off", 32'h3,
            {28'h0, pwr_o, ack_o, irq_o, fiq_o});
        evt(2'b01);
        for (int e = 0; e < 8; e++) begin
            cop(1'b1, 1'b0, 4'h1, 32'h0000_8000 | (e << 2), q);
            cop(1'b0, 1'b0, 4'h1, '0, q);
            chk("entry code", 32'h0000_8002 | (e << 2), q);
        end
    endtask
    task automatic t_flags();
        logic [31:0] q;
        pulse(0);
        host.xrd(5'h01, q);
        chk("h2c set", 32'h2, {30'h0, q[30:29]});
        pulse(2);
        chk("c2h set", 32'h3, {30'h0, h2c, c2h});
        pulse(1);
        chk("h2c clear", 32'h1, {30'h0, h2c, c2h});
        pulse(3);
        chk("c2h clear", 32'h0, {30'h0, h2c, c2h});
    endtask
    task automatic t_sticky();
        logic [31:0] q;
        pulse(4);
        cop(1'b0, 1'b0, 4'h1, '0, q);
        chk("core read keeps", 32'h1, {31'h0, q[7]});
        host.xrd(5'h01, q);
        chk("imprecise set", 32'h1, {31'h0, q[7]});
        host.xrd(5'h01, q);
        chk("imprecise clear", 32'h1, {30'h0, q[7], q[1]});
        pulse(7);
        host.xrd(5'h01, q);
        chk("halted", 32'h3, {30'h0, q[1:0]});
        host.xwr(5'h01, 32'h0000_2000);
        chk("exec ok", 32'h1, {31'h0, fex});
        pulse(5);
        host.xrd(5'h01, q);
        chk("precise set", 32'h1, {31'h0, q[6]});
        host.xrd(5'h01, q);
        chk("precise clear", 32'h0, {31'h0, q[6]});
        pulse(8);
        host.xrd(5'h01, q);
        chk("exiting", 32'h0, {30'h0, q[1:0]});
        pulse(9);
        host.xrd(5'h01, q);
        chk("exited", 32'h2, {30'h0, q[1:0]});
        host.xwr(5'h01, 32'h0);
    endtask
    task automatic t_user();
        logic [31:0] q;
        cop(1'b0, 1'b1, 4'h0, '0, q);
        chk("user allowed", 32'h0, {31'h0, undef});
        cop(1'b1, 1'b0, 4'h1, 32'h0000_1000, q);
        cop(1'b0, 1'b1, 4'h0, '0, q);
        chk("user trap", 32'h1, {31'h0, undef});
        chk("user data", 32'h0, q);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // cycle ceiling against a hung run
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 4000) begin
            bad_count++;
            report_and_stop();
        end
    end
    initial begin
        repeat (5) @(negedge core_clk);
        rst_b = 1'b1;
        t_ident();
        t_ctrl();
        t_flags();
        t_sticky();
        t_user();
        report_and_stop();
    end
endmodule
